// ===== ptcc_pkg.sv
// Purpose: Shared constants and types for the prescaled timer/counter with capture
// Assumes: Byte-wide register port, single cycle clock
// Notes: Register addresses are the printed offsets
`default_nettype none
package ptcc_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [15:0] ADDR_TIMER_CONTROL = 16'hFE10;
    localparam logic [15:0] ADDR_PRESCALER_MATCH = 16'hFE11;
    localparam logic [15:0] ADDR_COUNT_LOW = 16'hFE12;
    localparam logic [15:0] ADDR_COUNT_HIGH = 16'hFE13;
    localparam logic [15:0] ADDR_MATCH_DATA_LOW = 16'hFE14;
    localparam logic [15:0] ADDR_MATCH_DATA_HIGH = 16'hFE15;
    localparam logic [15:0] ADDR_CAPTURE_LOW = 16'hFE16;
    localparam logic [15:0] ADDR_CAPTURE_HIGH = 16'hFE17;

    // ==========================================================
    // Control register fields
    localparam int BIT_HIGH_RUN = 7;
    localparam int BIT_LOW_RUN = 6;
    localparam int BIT_CASCADE = 5;
    localparam int BIT_LOW_SRC = 4;
    localparam int BIT_HIGH_FLAG = 3;
    localparam int BIT_HIGH_IE = 2;
    localparam int BIT_LOW_FLAG = 1;
    localparam int BIT_LOW_IE = 0;

    // ==========================================================
    // Reset values and counting constants
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CAPTURE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // ==========================================================
    // Detection pulses, one clock wide, from the pin detection logic
    typedef struct packed {
        logic ext_irq_zero;
        logic ext_irq_one;
        logic ext_irq_two;
        logic ext_irq_three;
        logic low_capture_input;
        logic high_capture_input;
        logic count_input;
    } ptcc_det_s;

    // Register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ptcc_req_s;
endpackage
`default_nettype wire

// ===== ptcc_timer.sv
// Purpose: Sixteen-bit timer/counter from two byte halves with prescaler and capture
// Assumes: Detection inputs are single-cycle pulses on clk_sys
// Notes: Interrupt outputs lag the flag and enable by one clock
//
// Overview of operation
// RULE_01: Prescaler pulses when count equals match value
// RULE_02: Prescaler restarts on match or match write
// RULE_03: Prescaler halts only in deep standby
// RULE_04: Low counter runs only while bit 6 set
// RULE_05: High counter runs only while bit 7 set
// RULE_06: Bit 4 picks prescaler or external low clock
// RULE_07: Bit 5 picks prescaler or low match clock; the code clocks the high half from low byte overflow (lo_carry)
// RULE_08: Two control bits select four counting modes
// RULE_09: Sixteen-bit mode matches all sixteen bits
// RULE_10: Counters clear when stopped or on match
// RULE_11: Buffer tracks data stopped, loads on match
// RULE_12: External modes count one per detection pulse
// RULE_13: Byte mode low capture from low sources
// RULE_14: Sixteen-bit mode captures both bytes together
// RULE_15: High capture from high detection sources
// RULE_16: Interrupt request per half when enabled
// RULE_17: Period is match plus one clocks
// RULE_18: Match flags stick until software clears
// RULE_19: Flag and enable request half's vector
// RULE_20: Sixteen-bit mode sets both flags together
// RULE_21: Each detection pulse acts exactly once
// RULE_22: Count reads live, read-only writes ignored
//
// Our own choice: strobed register access.
`default_nettype none
module ptcc_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire ptcc_pkg::ptcc_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Power state and detection pulses
    input wire logic hold_mode,
    input wire ptcc_pkg::ptcc_det_s det,
    // Interrupt requests: low half vector 0013H, high half vector 0023H
    output logic irq_low,
    output logic irq_high
);
    // ==========================================================
    // Register port decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction

    logic [7:0] ctrl_q;
    logic [7:0] prr_q;
    logic [7:0] lo_data_q;
    logic [7:0] hi_data_q;
    logic [7:0] lo_buf_q;
    logic [7:0] hi_buf_q;
    logic [7:0] lo_cnt_q;
    logic [7:0] hi_cnt_q;
    logic [7:0] pre_cnt_q;
    logic [7:0] cap_lo_q;
    logic [7:0] cap_hi_q;
    logic wr_ctrl;
    logic wr_prr;
    logic wr_lo_data;
    logic wr_hi_data;

    assign wr_ctrl = reg_req.wr && hit(reg_req.addr, ptcc_pkg::ADDR_TIMER_CONTROL);
    assign wr_prr = reg_req.wr && hit(reg_req.addr, ptcc_pkg::ADDR_PRESCALER_MATCH);
    assign wr_lo_data = reg_req.wr && hit(reg_req.addr, ptcc_pkg::ADDR_MATCH_DATA_LOW);
    assign wr_hi_data = reg_req.wr && hit(reg_req.addr, ptcc_pkg::ADDR_MATCH_DATA_HIGH);

    // ==========================================================
    // Control fields
    logic high_run_enable;
    logic low_run_enable;
    logic cascade_16bit_select;
    logic low_clock_source_select;

    assign high_run_enable = ctrl_q[ptcc_pkg::BIT_HIGH_RUN];
    assign low_run_enable = ctrl_q[ptcc_pkg::BIT_LOW_RUN];
    assign cascade_16bit_select = ctrl_q[ptcc_pkg::BIT_CASCADE];
    assign low_clock_source_select = ctrl_q[ptcc_pkg::BIT_LOW_SRC];

    // ==========================================================
    // Prescaler
    logic pre_match;

    assign pre_match = !hold_mode && (pre_cnt_q == prr_q); // [RULE_01] [RULE_03]

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_cnt_q <= ptcc_pkg::RST_BYTE;
        end
        else if (wr_prr || pre_match)
        begin
            pre_cnt_q <= ptcc_pkg::RST_BYTE; // [RULE_02]
        end
        else if (!hold_mode)
        begin
            pre_cnt_q <= pre_cnt_q + ptcc_pkg::COUNT_STEP; // [RULE_03]
        end
    end

    // ==========================================================
    // Count clocks and match pulses
    logic lo_clk;
    logic hi_clk;
    logic lo_match;
    logic hi_match;
    logic full_match;
    logic lo_carry;

    // Mode select: cascade then low source gives modes 0..3
    assign lo_clk = low_clock_source_select ? det.count_input : pre_match; // [RULE_06] [RULE_08] [RULE_12] [RULE_21]
    assign full_match = low_run_enable && lo_clk
        && ({hi_cnt_q, lo_cnt_q} == {hi_buf_q, lo_buf_q}); // [RULE_09] [RULE_17]
    assign lo_carry = low_run_enable && lo_clk && (lo_cnt_q == ptcc_pkg::BYTE_MAX);
    assign hi_clk = cascade_16bit_select ? lo_carry : pre_match; // [RULE_07]
    assign lo_match = cascade_16bit_select ? full_match
        : (low_run_enable && lo_clk && (lo_cnt_q == lo_buf_q)); // [RULE_17]
    assign hi_match = cascade_16bit_select ? full_match
        : (high_run_enable && hi_clk && (hi_cnt_q == hi_buf_q));

    // ==========================================================
    // Low byte counter and buffer
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            lo_cnt_q <= ptcc_pkg::RST_BYTE;
        end
        else if (!low_run_enable || lo_match)
        begin
            lo_cnt_q <= ptcc_pkg::RST_BYTE; // [RULE_04] [RULE_10]
        end
        else if (lo_clk)
        begin
            lo_cnt_q <= lo_cnt_q + ptcc_pkg::COUNT_STEP; // [RULE_12]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            lo_buf_q <= ptcc_pkg::RST_BYTE;
        end
        else if (!low_run_enable || lo_match)
        begin
            lo_buf_q <= lo_data_q; // [RULE_11]
        end
    end

    // ==========================================================
    // High byte counter and buffer
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hi_cnt_q <= ptcc_pkg::RST_BYTE;
        end
        else if (!high_run_enable || hi_match)
        begin
            hi_cnt_q <= ptcc_pkg::RST_BYTE; // [RULE_05] [RULE_10]
        end
        else if (hi_clk)
        begin
            hi_cnt_q <= hi_cnt_q + ptcc_pkg::COUNT_STEP;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hi_buf_q <= ptcc_pkg::RST_BYTE;
        end
        else if (!high_run_enable || hi_match)
        begin
            hi_buf_q <= hi_data_q; // [RULE_11]
        end
    end

    // ==========================================================
    // Capture
    logic cap_lo_src;
    logic cap_hi_src;

    assign cap_lo_src = det.ext_irq_zero || det.ext_irq_two || det.low_capture_input;
    assign cap_hi_src = det.ext_irq_one || det.ext_irq_three || det.high_capture_input;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cap_lo_q <= ptcc_pkg::RST_CAPTURE;
        end
        else if (cascade_16bit_select ? cap_hi_src : cap_lo_src)
        begin
            cap_lo_q <= lo_cnt_q; // [RULE_13] [RULE_14] [RULE_21]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cap_hi_q <= ptcc_pkg::RST_CAPTURE;
        end
        else if (cap_hi_src)
        begin
            cap_hi_q <= hi_cnt_q; // [RULE_15] [RULE_14]
        end
    end

    // ==========================================================
    // Writable registers; a match sets its flag over a clearing write
    logic [7:0] ctrl_d;

    always_comb
    begin
        ctrl_d = wr_ctrl ? reg_req.wdata : ctrl_q;
        ctrl_d[ptcc_pkg::BIT_LOW_FLAG] = ctrl_d[ptcc_pkg::BIT_LOW_FLAG] | lo_match; // [RULE_18]
        ctrl_d[ptcc_pkg::BIT_HIGH_FLAG] = ctrl_d[ptcc_pkg::BIT_HIGH_FLAG] | hi_match; // [RULE_18] [RULE_20]
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= ptcc_pkg::RST_BYTE;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            prr_q <= ptcc_pkg::RST_BYTE;
            lo_data_q <= ptcc_pkg::RST_BYTE;
            hi_data_q <= ptcc_pkg::RST_BYTE;
        end
        else
        begin
            if (wr_prr)
            begin
                prr_q <= reg_req.wdata;
            end
            if (wr_lo_data)
            begin
                lo_data_q <= reg_req.wdata;
            end
            if (wr_hi_data)
            begin
                hi_data_q <= reg_req.wdata;
            end
        end
    end

    // ==========================================================
    // Interrupt requests
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_low <= 1'b0;
            irq_high <= 1'b0;
        end
        else
        begin
            irq_low <= ctrl_q[ptcc_pkg::BIT_LOW_FLAG] && ctrl_q[ptcc_pkg::BIT_LOW_IE]; // [RULE_16] [RULE_19]
            irq_high <= ctrl_q[ptcc_pkg::BIT_HIGH_FLAG] && ctrl_q[ptcc_pkg::BIT_HIGH_IE]; // [RULE_16] [RULE_19]
        end
    end

    // ==========================================================
    // Read port; unmapped addresses read zero
    logic [7:0] rd_mux;

    always_comb
    begin
        unique case (reg_req.addr)
            ptcc_pkg::ADDR_TIMER_CONTROL: rd_mux = ctrl_q;
            ptcc_pkg::ADDR_PRESCALER_MATCH: rd_mux = prr_q;
            ptcc_pkg::ADDR_COUNT_LOW: rd_mux = lo_cnt_q; // [RULE_22]
            ptcc_pkg::ADDR_COUNT_HIGH: rd_mux = hi_cnt_q; // [RULE_22]
            ptcc_pkg::ADDR_MATCH_DATA_LOW: rd_mux = lo_data_q;
            ptcc_pkg::ADDR_MATCH_DATA_HIGH: rd_mux = hi_data_q;
            ptcc_pkg::ADDR_CAPTURE_LOW: rd_mux = cap_lo_q;
            ptcc_pkg::ADDR_CAPTURE_HIGH: rd_mux = cap_hi_q;
            default: rd_mux = ptcc_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= ptcc_pkg::RST_BYTE;
        end
        else if (reg_req.rd)
        begin
            reg_rdata <= rd_mux;
        end
        else
        begin
            reg_rdata <= ptcc_pkg::RST_BYTE;
        end
    end
endmodule
`default_nettype wire

// ===== ptcc_timer_assertions.sv
// Purpose: Port-level assertions for the timer/counter
// Assumes: Only software writes the run, mode and enable bits
// Notes: Shadows hold the last written control and prescaler bytes
`default_nettype none
module ptcc_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire ptcc_pkg::ptcc_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    // Standby, pulses and requests
    input wire logic hold_mode,
    input wire ptcc_pkg::ptcc_det_s det,
    input wire logic irq_low,
    input wire logic irq_high
);
    logic [7:0] ctl_q;
    logic [7:0] pre_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Shadows of software-written bytes
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_q <= 8'h00;
            pre_q <= 8'h00;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == ptcc_pkg::ADDR_TIMER_CONTROL)
                ctl_q <= reg_req.wdata;
            if (reg_req.addr == ptcc_pkg::ADDR_PRESCALER_MATCH)
                pre_q <= reg_req.wdata;
        end
    end
    sequence rd_s(logic [15:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    // ==========================================================
    // Assertions
    idle_read_zero_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (reg_req.rd && reg_req.addr[15:3] != 13'h1FC2
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    prescale_back_a: assert property (rd_s(ptcc_pkg::ADDR_PRESCALER_MATCH)
        |=> reg_rdata == $past(pre_q)) else $error("prescaler match readback wrong");
    control_back_a: assert property (rd_s(ptcc_pkg::ADDR_TIMER_CONTROL)
        |=> (reg_rdata & 8'hF5) == ($past(ctl_q) & 8'hF5)) else $error("control readback wrong");
    // The count clears one clock after the run bit drops, so it must be stopped twice over
    low_stop_zero_a: assert property (rd_s(ptcc_pkg::ADDR_COUNT_LOW)
        ##0 !ctl_q[ptcc_pkg::BIT_LOW_RUN] && !$past(ctl_q[ptcc_pkg::BIT_LOW_RUN])
        |=> reg_rdata == 8'h00) else $error("stopped count");
    low_irq_gate_a: assert property (irq_low |-> $past(ctl_q[ptcc_pkg::BIT_LOW_IE]))
        else $error("low request without enable");
    high_irq_gate_a: assert property (irq_high |-> $past(ctl_q[ptcc_pkg::BIT_HIGH_IE]))
        else $error("high request without enable");
    low_irq_clear_a: assert property ($fell(irq_low) |->
        $past(reg_req.wr && reg_req.addr == ptcc_pkg::ADDR_TIMER_CONTROL, 2))
        else $error("low request dropped without a control write");
endmodule
bind ptcc_timer ptcc_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .hold_mode(hold_mode), .det(det), .irq_low(irq_low),
    .irq_high(irq_high));
`default_nettype wire

// ===== ptcc_det_src.sv
// Purpose: Pin detection logic model sending bursts of pulses
// Assumes: Bench raises start for one cycle with kind, count and gap
// Notes: Kind is the bit index within the detection struct
`default_nettype none
module ptcc_det_src (
    // Clock and burst request
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [2:0] kind,
    input wire logic [8:0] num,
    input wire logic [3:0] gap,
    // Pulses and status
    output ptcc_pkg::ptcc_det_s det,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] pulse_q = 7'h00;
    logic [8:0] left_q = 9'h000;
    logic [3:0] wait_q = 4'h0;
    logic [2:0] kind_q = 3'h0;
    assign det = pulse_q;
    assign busy = start || left_q != 9'h000;
    always @(posedge clk_sys)
    begin
        pulse_q <= 7'h00;
        if (start)
        begin
            left_q <= num;
            kind_q <= kind;
            wait_q <= 4'h0;
        end
        else if (left_q != 9'h000 && wait_q == 4'h0)
        begin
            pulse_q <= 7'h01 << kind_q;
            left_q <= left_q - 9'h001;
            wait_q <= gap;
        end
        else if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
    end
endmodule
`default_nettype wire

// ===== ptcc_timer_tb.sv
// Purpose: Self-checking bench for the timer/counter
// Assumes: Pulse kinds 0 count, 2/4/6 low capture, 3/5 high capture
// Notes: Addresses are the control address plus an offset
`default_nettype none
module ptcc_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] A0 = ptcc_pkg::ADDR_TIMER_CONTROL;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hold_mode = 1'b0;
    ptcc_pkg::ptcc_req_s reg_req = '0;
    ptcc_pkg::ptcc_det_s det;
    logic [7:0] reg_rdata;
    logic irq_low;
    logic irq_high;
    logic busy;
    logic start = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [8:0] num = 9'h000;
    logic [3:0] gap = 4'h0;
    logic [7:0] rd_v;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    ptcc_timer u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .hold_mode(hold_mode), .det(det), .irq_low(irq_low), .irq_high(irq_high));
    ptcc_det_src u_src (.clk_sys(clk_sys), .start(start), .kind(kind), .num(num), .gap(gap),
        .det(det), .busy(busy));
    // ==========================================================
    // Access tasks
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1 rd_v = reg_rdata;
        chk(what, {8'h00, rd_v}, {8'h00, exp});
    endtask
    task automatic pulses(input logic [2:0] k, input logic [8:0] n, input logic [3:0] g);
        int i;
        @(posedge clk_sys);
        kind <= k;
        num <= n;
        gap <= g;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        for (i = 0; i < 3000; i++)
        begin
            #1;
            if (busy !== 1'b1)
                break;
            @(posedge clk_sys);
        end
        if (i == 3000)
        begin
            errors++;
            report_and_stop();
        end
        @(posedge clk_sys);
    endtask
    task automatic wait_irq(output int t);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (irq_low === 1'b1)
                break;
        end
        if (i == 3000)
        begin
            errors++;
            report_and_stop();
        end
        t = cyc;
    endtask
    // ==========================================================
    // Scenarios
    initial
    begin
        int t1;
        int t2;
        int k;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        for (k = 0; k < 9; k++)
            rchk("reset value", A0 + 16'(k), 8'h00);
        for (k = 2; k < 8; k++)
        begin
            if (k[2:1] != 2'b10)
            begin
                wr(A0 + 16'(k), 8'hFF);
                rchk("read-only write", A0 + 16'(k), 8'h00);
            end
        end
        // Timer periods: dual byte mode, then cascaded mode
        for (k = 0; k < 2; k++)
        begin
            wr(A0, 8'h00);
            wr(A0 + 16'h1, k ? 8'h01 : 8'h02);
            wr(A0 + 16'h4, k ? 8'h02 : 8'h03);
            wr(A0 + 16'h5, 8'h01);
            wr(A0, k ? 8'hE1 : 8'h41);
            wait_irq(t1);
            wr(A0, k ? 8'hE1 : 8'h41);
            wait_irq(t2);
            chk("period", 16'(t2 - t1), k ? 16'h0206 : 16'h000C);
            rchk("flags", A0, k ? 8'hEB : 8'h43);
        end
        // Masked request, sticky flag, then enable
        wr(A0, 8'h00);
        wr(A0 + 16'h1, 8'h00);
        wr(A0 + 16'h4, 8'h03);
        wr(A0, 8'h40);
        repeat (30) @(posedge clk_sys);
        #1 chk("masked irq", {15'h0, irq_low}, 16'h0000);
        rchk("sticky flag", A0, 8'h42);
        wr(A0, 8'h43);
        repeat (2) @(posedge clk_sys);
        #1 chk("enabled irq", {15'h0, irq_low}, 16'h0001);
        // Deep standby freezes the prescaler
        wr(A0, 8'h00);
        wr(A0 + 16'h4, 8'hFF);
        @(posedge clk_sys);
        hold_mode <= 1'b1;
        wr(A0, 8'h40);
        repeat (10) @(posedge clk_sys);
        rchk("held count", A0 + 16'h2, 8'h00);
        @(posedge clk_sys);
        hold_mode <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rchk("running count", A0 + 16'h2, 8'h03);
        chk("count moved", {15'h0, rd_v != 8'h00}, 16'h0001);
        wr(A0, 8'h00);
        rchk("stopped count", A0 + 16'h2, 8'h00);
        // Writes every second clock keep the prescaler from reaching its match
        wr(A0 + 16'h1, 8'hFF);
        wr(A0, 8'h40);
        repeat (3) wr(A0 + 16'h1, 8'h04);
        rchk("restarted prescaler", A0 + 16'h2, 8'h00);
        rchk("prescaler readback", A0 + 16'h1, 8'h04);
        // High half runs on its own while the low half stays cleared
        wr(A0, 8'h00);
        wr(A0 + 16'h1, 8'h00);
        wr(A0 + 16'h5, 8'hFF);
        wr(A0, 8'h80);
        rchk("high runs alone", A0 + 16'h3, 8'h01);
        rchk("low stays stopped", A0 + 16'h2, 8'h00);
        // Match data written while running waits for the next match
        wr(A0, 8'h00);
        wr(A0 + 16'h4, 8'h02);
        wr(A0, 8'h50);
        wr(A0 + 16'h4, 8'h05);
        pulses(3'h0, 9'h003, 4'h0);
        rchk("buffer held", A0 + 16'h2, 8'h00);
        pulses(3'h0, 9'h003, 4'h0);
        rchk("buffer reloaded", A0 + 16'h2, 8'h03);
        wr(A0, 8'h00);
        // External low counter and every low capture source
        wr(A0 + 16'h4, 8'h04);
        wr(A0, 8'h51);
        for (k = 0; k < 3; k++)
        begin
            pulses(3'h0, 9'h001, 4'h0);
            pulses(3'(2 + 2 * k), 9'h001, 4'h0);
            rchk("low capture", A0 + 16'h6, 8'(k + 1));
        end
        pulses(3'h5, 9'h001, 4'h0);
        rchk("high capture", A0 + 16'h7, 8'h00);
        pulses(3'h0, 9'h001, 4'h2);
        rchk("ext count", A0 + 16'h2, 8'h04);
        pulses(3'h0, 9'h001, 4'h0);
        rchk("ext match", A0 + 16'h2, 8'h00);
        rchk("ext flag", A0, 8'h53);
        // Cascaded external counter
        wr(A0, 8'h00);
        wr(A0 + 16'h4, 8'h01);
        wr(A0 + 16'h5, 8'h01);
        wr(A0, 8'hF5);
        pulses(3'h0, 9'h101, 4'h0);
        rchk("wide low", A0 + 16'h2, 8'h01);
        rchk("wide high", A0 + 16'h3, 8'h01);
        rchk("no early match", A0, 8'hF5);
        pulses(3'h3, 9'h001, 4'h0);
        rchk("wide cap low", A0 + 16'h6, 8'h01);
        rchk("wide cap high", A0 + 16'h7, 8'h01);
        pulses(3'h0, 9'h001, 4'h3);
        rchk("both flags", A0, 8'hFF);
        chk("both irqs", {14'h0, irq_low, irq_high}, 16'h0003);
        report_and_stop();
    end
endmodule
`default_nettype wire
